// file: tmr_core.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module tmr_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_wave_a,
  output logic o_wave_a_oe,
  output logic o_wave_b,
  output logic o_wave_b_oe
);
  typedef struct packed {
    logic [9:0] pre;
    logic [15:0] cnt;
    logic blk;
    logic [3:0] mode;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] cs;
    logic dir_a;
    logic dir_b;
    logic [15:0] ocr_a;
    logic [15:0] ocr_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capt;
    logic [3:0] flags;
    logic wav_a;
    logic wav_b;
    logic pin_a;
    logic pin_b;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tmr_state_t;

  tmr_state_t s;
  tmr_state_t next_s;

  // ==========================================================
  // decoded mode
  logic tick;
  logic is_pwm;
  logic is_clr;
  logic var_top;
  logic fixed_top;
  logic [15:0] top;
  logic [9:0] pmask;
  logic top_hit;
  logic match_a;
  logic match_b;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [15:0] cval;
  logic [3:0] fset;

  // one latch update; action select never touches the count
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
      input logic match, input logic at_top, input logic pwm,
      input logic tog_ok);
    logic r;
    r = cur;
    if (!pwm) begin
      if (match) begin
        case (act)
          tmr_pkg::ACT_TOGGLE: r = ~cur;
          tmr_pkg::ACT_CLEAR: r = 1'b0;
          tmr_pkg::ACT_SET: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else begin
      // match wins over top so compare equal to top holds one level
      case (act)
        tmr_pkg::ACT_TOGGLE: r = (match && tog_ok) ? ~cur : cur;
        tmr_pkg::ACT_CLEAR: r = match ? 1'b1 : (at_top ? 1'b0 : cur);
        tmr_pkg::ACT_SET: r = match ? 1'b0 : (at_top ? 1'b1 : cur);
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    is_pwm = 1'b0;
    is_clr = 1'b0;
    var_top = 1'b0;
    fixed_top = 1'b0;
    top = tmr_pkg::CNT_MAX;
    case (s.mode)
      tmr_pkg::MODE_CLR_A: begin
        is_clr = 1'b1;
        var_top = 1'b1;
        top = s.ocr_a;
      end
      tmr_pkg::MODE_CLR_CAPT: begin
        is_clr = 1'b1;
        var_top = 1'b1;
        top = s.capt;
      end
      tmr_pkg::MODE_PWM8: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top = tmr_pkg::TOP_8;
      end
      tmr_pkg::MODE_PWM9: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top = tmr_pkg::TOP_9;
      end
      tmr_pkg::MODE_PWM10: begin
        is_pwm = 1'b1;
        fixed_top = 1'b1;
        top = tmr_pkg::TOP_10;
      end
      tmr_pkg::MODE_PWM_CAPT: begin
        is_pwm = 1'b1;
        var_top = 1'b1;
        top = s.capt;
      end
      tmr_pkg::MODE_PWM_A: begin
        is_pwm = 1'b1;
        var_top = 1'b1;
        top = s.ocr_a;
      end
      default: top = tmr_pkg::CNT_MAX;
    endcase
    case (s.cs)
      tmr_pkg::CS_DIV8: pmask = tmr_pkg::PM_8;
      tmr_pkg::CS_DIV64: pmask = tmr_pkg::PM_64;
      tmr_pkg::CS_DIV256: pmask = tmr_pkg::PM_256;
      tmr_pkg::CS_DIV1024: pmask = tmr_pkg::PM_1024;
      default: pmask = 10'h000;
    endcase
    tick = (s.cs != tmr_pkg::CS_STOP) && (s.cs <= tmr_pkg::CS_DIV1024) &&
           ((s.pre & pmask) == pmask);
    // a blocked cycle also hides a variable top, so the count runs on
    top_hit = (is_pwm || is_clr) && (s.cnt == top) &&
              !(s.blk && var_top);
    match_a = (s.cnt == s.ocr_a) && !s.blk;
    match_b = (s.cnt == s.ocr_b) && !s.blk;
    do_write = s.aw_have && s.w_have && !s.bvalid;
    wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}},
             {8{s.wstrb[0]}}};
    wval = s.wdata & wmask;
    // fixed tops keep only the bits inside the top width
    cval = fixed_top ? (wval[15:0] & top) : wval[15:0];
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    fset = 4'h0;
    next_s.pre = (s.cs == tmr_pkg::CS_STOP) ? 10'h000 : s.pre + 10'h001;
    if (tick && (is_pwm || is_clr || s.mode == tmr_pkg::MODE_NORMAL)) begin
      next_s.blk = 1'b0;
      if (top_hit) begin
        next_s.cnt = tmr_pkg::VAL_RST;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
      if (!is_pwm && s.cnt == tmr_pkg::CNT_MAX) begin
        fset[tmr_pkg::FLG_WRAP] = 1'b1;
      end
      if (is_pwm && top_hit) begin
        fset[tmr_pkg::FLG_WRAP] = 1'b1;
        next_s.ocr_a = s.buf_a;
        next_s.ocr_b = s.buf_b;
      end
      if (top_hit && s.mode == tmr_pkg::MODE_CLR_CAPT) begin
        fset[tmr_pkg::FLG_CAPT] = 1'b1;
      end
      if (top_hit && s.mode == tmr_pkg::MODE_PWM_CAPT) begin
        fset[tmr_pkg::FLG_CAPT] = 1'b1;
      end
      // compare A as top sets its flag through the match path
      fset[tmr_pkg::FLG_CMPA] = match_a;
      fset[tmr_pkg::FLG_CMPB] = match_b;
      next_s.wav_a = wave_next(s.wav_a, s.act_a, match_a, top_hit, is_pwm,
                               s.mode == tmr_pkg::MODE_PWM_A);
      next_s.wav_b = wave_next(s.wav_b, s.act_b, match_b, top_hit, is_pwm,
                               1'b0);
    end
    // any other mode code leaves count, flags and latches as they are

    // ---------------- bus channels
    if (i_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = i_awaddr;
    end
    if (i_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata = i_wdata;
      next_s.wstrb = i_wstrb;
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.flags = s.flags;
    if (do_write) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = tmr_pkg::RESP_OKAY;
      case ({s.awaddr[7:2], 2'b00})
        tmr_pkg::OFF_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.mode = s.wdata[tmr_pkg::MODE_LSB +: 4];
            next_s.act_a = s.wdata[tmr_pkg::COMA_LSB +: 2];
            next_s.act_b = s.wdata[tmr_pkg::COMB_LSB +: 2];
          end
          if (s.wstrb[1]) begin
            next_s.cs = s.wdata[tmr_pkg::CS_LSB +: 3];
            next_s.dir_a = s.wdata[tmr_pkg::DIRA_BIT];
            next_s.dir_b = s.wdata[tmr_pkg::DIRB_BIT];
          end
        end
        tmr_pkg::OFF_COUNT: begin
          // a load overrides the tick in the same cycle
          next_s.cnt = wval[15:0] | (s.cnt & ~wmask[15:0]);
          next_s.blk = 1'b1;
        end
        tmr_pkg::OFF_CMPA: begin
          next_s.buf_a = cval;
          if (!is_pwm) begin
            next_s.ocr_a = cval;
          end
        end
        tmr_pkg::OFF_CMPB: begin
          next_s.buf_b = cval;
          if (!is_pwm) begin
            next_s.ocr_b = cval;
          end
        end
        tmr_pkg::OFF_CAPT: begin
          next_s.capt = wval[15:0] | (s.capt & ~wmask[15:0]);
        end
        tmr_pkg::OFF_FLAGS: begin
          next_s.flags = s.flags & ~wval[3:0];
        end
        default: next_s.bresp = tmr_pkg::RESP_SLVERR;
      endcase
    end
    next_s.flags = next_s.flags | fset;
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;

    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (i_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = tmr_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case ({i_araddr[7:2], 2'b00})
        tmr_pkg::OFF_CTRL: begin
          next_s.rdata[tmr_pkg::MODE_LSB +: 4] = s.mode;
          next_s.rdata[tmr_pkg::COMA_LSB +: 2] = s.act_a;
          next_s.rdata[tmr_pkg::COMB_LSB +: 2] = s.act_b;
          next_s.rdata[tmr_pkg::CS_LSB +: 3] = s.cs;
          next_s.rdata[tmr_pkg::DIRA_BIT] = s.dir_a;
          next_s.rdata[tmr_pkg::DIRB_BIT] = s.dir_b;
        end
        tmr_pkg::OFF_COUNT: next_s.rdata[15:0] = s.cnt;
        tmr_pkg::OFF_CMPA: next_s.rdata[15:0] = s.buf_a;
        tmr_pkg::OFF_CMPB: next_s.rdata[15:0] = s.buf_b;
        tmr_pkg::OFF_CAPT: next_s.rdata[15:0] = s.capt;
        tmr_pkg::OFF_FLAGS: next_s.rdata[3:0] = s.flags;
        default: next_s.rresp = tmr_pkg::RESP_SLVERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // latches keep running while the pin is an input
    next_s.pin_a = next_s.dir_a && next_s.wav_a;
    next_s.pin_b = next_s.dir_b && next_s.wav_b;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arready;
  assign o_rvalid = s.rvalid;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;
  assign o_wave_a = s.pin_a;
  assign o_wave_a_oe = s.dir_a;
  assign o_wave_b = s.pin_b;
  assign o_wave_b_oe = s.dir_b;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_normal_wrap: assert property (
    i_ce && tick && s.mode == tmr_pkg::MODE_NORMAL &&
    s.cnt == tmr_pkg::CNT_MAX && !do_write
    |=> s.cnt == 16'h0000 && s.flags[tmr_pkg::FLG_WRAP])
    else $error("normal mode wrap missed");
  a_match_clear: assert property (
    i_ce && tick && s.mode == tmr_pkg::MODE_CLR_A && top_hit && !do_write
    |=> s.cnt == 16'h0000 && s.flags[tmr_pkg::FLG_CMPA])
    else $error("clear on match failed");
  a_pwm_top_load: assert property (
    i_ce && tick && is_pwm && top_hit && !do_write
    |=> s.cnt == 16'h0000 && s.flags[tmr_pkg::FLG_WRAP] &&
        s.ocr_a == $past(s.buf_a))
    else $error("pwm top update wrong");
  a_block_match: assert property (
    i_ce && tick && s.blk && !s.flags[tmr_pkg::FLG_CMPB]
    |=> !s.flags[tmr_pkg::FLG_CMPB])
    else $error("blocked match set flag");
  a_hold_no_tick: assert property (
    i_ce && !tick && !do_write |=> $stable(s.cnt) && $stable(s.wav_a))
    else $error("count moved without tick");
  a_pin_gate: assert property (
    !o_wave_a_oe |-> !o_wave_a)
    else $error("latch on input pin");
  a_match_toggle: assert property (
    i_ce && tick && s.mode == tmr_pkg::MODE_CLR_A &&
    s.act_a == tmr_pkg::ACT_TOGGLE && match_a
    |=> s.wav_a != $past(s.wav_a))
    else $error("toggle missed");
  a_flag_set_wins: assert property (
    i_ce && tick && match_b && s.mode == tmr_pkg::MODE_NORMAL
    |=> s.flags[tmr_pkg::FLG_CMPB])
    else $error("compare flag lost");
  a_fixed_mask: assert property (
    i_ce && do_write && fixed_top &&
    {s.awaddr[7:2], 2'b00} == tmr_pkg::OFF_CMPA
    |=> (s.buf_a & ~$past(top)) == 16'h0000)
    else $error("fixed top mask missing");
  a_pwm_clear_top: assert property (
    i_ce && tick && is_pwm && s.act_a == tmr_pkg::ACT_CLEAR &&
    top_hit && !match_a
    |=> !s.wav_a)
    else $error("pwm top clear missed");
endmodule

// file: tmr_pkg.sv
package tmr_pkg;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CMPA = 8'h08;
  localparam logic [7:0] OFF_CMPB = 8'h0C;
  localparam logic [7:0] OFF_CAPT = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  // ==========================================================
  // control fields
  localparam int MODE_LSB = 0;
  localparam int COMA_LSB = 4;
  localparam int COMB_LSB = 6;
  localparam int CS_LSB = 8;
  localparam int DIRA_BIT = 12;
  localparam int DIRB_BIT = 13;
  // flag bits
  localparam int FLG_WRAP = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // ==========================================================
  // reset values and fixed counts
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // ==========================================================
  // mode codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLR_A = 4'h4;
  localparam logic [3:0] MODE_PWM8 = 4'h5;
  localparam logic [3:0] MODE_PWM9 = 4'h6;
  localparam logic [3:0] MODE_PWM10 = 4'h7;
  localparam logic [3:0] MODE_CLR_CAPT = 4'hC;
  localparam logic [3:0] MODE_PWM_CAPT = 4'hE;
  localparam logic [3:0] MODE_PWM_A = 4'hF;
  // output actions
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescaler source select and divide masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PM_8 = 10'h007;
  localparam logic [9:0] PM_64 = 10'h03F;
  localparam logic [9:0] PM_256 = 10'h0FF;
  localparam logic [9:0] PM_1024 = 10'h3FF;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: tmr_pin_load.sv
`timescale 1ns/10ps
module tmr_pin_load (
  input wire logic i_level,
  input wire logic i_oe,
  output logic o_pin
);
  // ==========================================
  // external load with a weak pull-down
  // an undriven pin reads low, never the last driven value
  assign o_pin = i_oe ? i_level : 1'b0;
endmodule

// file: timer16_normal_ctc_fastpwm_tb_top.sv
`timescale 1ns/10ps
module timer16_normal_ctc_fastpwm_tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic wave_a, oe_a, wave_b, oe_b, pin_a, pin_b;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'h3600DEFB;
  int div[5] = '{1, 8, 64, 256, 1024};

  always #2 i_clk = ~i_clk;

  tmr_core dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .o_wave_a(wave_a),
    .o_wave_a_oe(oe_a), .o_wave_b(wave_b), .o_wave_b_oe(oe_b));
  tmr_pin_load load_a_u (.i_level(wave_a), .i_oe(oe_a), .o_pin(pin_a));
  tmr_pin_load load_b_u (.i_level(wave_b), .i_oe(oe_b), .o_pin(pin_b));

  // ==========================================
  // reporting
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge i_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, tmr_pkg::RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask

  // ==========================================
  // expectations
  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:1] == 3'h7 || (m >= tmr_pkg::MODE_PWM8 &&
      m <= tmr_pkg::MODE_PWM10);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m,
      input logic [15:0] c, input logic [15:0] cap);
    case (m)
      tmr_pkg::MODE_PWM8: return tmr_pkg::TOP_8;
      tmr_pkg::MODE_PWM9: return tmr_pkg::TOP_9;
      tmr_pkg::MODE_PWM10: return tmr_pkg::TOP_10;
      tmr_pkg::MODE_CLR_CAPT, tmr_pkg::MODE_PWM_CAPT: return cap;
      default: return c;
    endcase
  endfunction

  // high cycles of channel A over two periods
  function automatic int exp_high(input logic [3:0] m, input logic [1:0] a,
      input logic [15:0] c, input logic [15:0] t);
    int h;
    if (a == tmr_pkg::ACT_TOGGLE) return t + 1;
    if (!is_pwm(m)) return (a == tmr_pkg::ACT_SET) ? 2 * (t + 1) : 0;
    h = (c == t) ? t + 1 : t - c;
    if (a == tmr_pkg::ACT_SET) h = t + 1 - h;
    return 2 * h;
  endfunction

  // count from zero, run, count high level at the pin, check flags
  task automatic run_case(input logic [3:0] m, input logic [1:0] a,
      input logic [15:0] c, input logic [15:0] cap);
    logic [15:0] t;
    int hi;
    int hib;
    t = top_of(m, c, cap);
    hi = 0;
    hib = 0;
    wok(tmr_pkg::OFF_CTRL, 32'h0);
    wok(tmr_pkg::OFF_CMPA, {16'h0, c});
    wok(tmr_pkg::OFF_CMPB, {16'h0, c});
    wok(tmr_pkg::OFF_CAPT, {16'h0, cap});
    wok(tmr_pkg::OFF_COUNT, 32'h0);
    wok(tmr_pkg::OFF_FLAGS, 32'hF);
    wok(tmr_pkg::OFF_CTRL, {18'h0, 2'h3, 1'b0, tmr_pkg::CS_DIV1, a, a, m});
    repeat (3 * (t + 1) + 8) @(posedge i_clk);
    repeat (2 * (t + 1)) begin
      @(negedge i_clk);
      hi += pin_a;
      hib += pin_b;
    end
    wok(tmr_pkg::OFF_CTRL, 32'h0);
    chk(32'(hi), 32'(exp_high(m, a, c, t)));
    // channel B ignores the toggle action in every PWM mode
    if (a == tmr_pkg::ACT_TOGGLE && is_pwm(m)) begin
      chk(32'(hib == 0 || hib == 2 * (t + 1)), 32'h1);
    end else begin
      chk(32'(hib), 32'(exp_high(m, a, c, t)));
    end
    rchk(tmr_pkg::OFF_FLAGS, {28'h0, m[3] & ~m[0], 2'h3, is_pwm(m)},
      32'hF);
    $display("case mode %h action %h done", m, a);
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d, d2;
    logic [1:0] r;
    logic [15:0] c, cap;
    int hi;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0, 32'hFFFFFFFF);
    rd(8'h18, d, r);
    chk({r, d[29:0]}, {tmr_pkg::RESP_SLVERR, 30'h0});
    wr(8'h18, 32'h1, r);
    chk({30'h0, r}, {30'h0, tmr_pkg::RESP_SLVERR});
    $display("reset and map test done");
    for (int i = 0; i < 5; i++) begin
      wok(tmr_pkg::OFF_COUNT, 32'h0);
      wok(tmr_pkg::OFF_CTRL, {21'h0, 3'(i + 1), 8'h00});
      repeat (4 * div[i]) @(posedge i_clk);
      wok(tmr_pkg::OFF_CTRL, 32'h0);
      rd(tmr_pkg::OFF_COUNT, d, r);
      chk(32'(d >= 4 && d <= 5 + 8 / div[i]), 32'h1);
      rd(tmr_pkg::OFF_COUNT, d2, r);
      chk(d2, d);
    end
    $display("prescaler test done");
    wok(tmr_pkg::OFF_CTRL, {21'h0, tmr_pkg::CS_DIV1, 8'h00});
    wok(tmr_pkg::OFF_COUNT, 32'h0000FFF0);
    wok(tmr_pkg::OFF_FLAGS, 32'hF);
    repeat (30) @(posedge i_clk);
    rchk(tmr_pkg::OFF_FLAGS, 32'h1, 32'h1);
    rd(tmr_pkg::OFF_COUNT, d, r);
    chk(32'(d < 32'h40), 32'h1);
    // a low enable freezes the count along with the bus
    i_ce <= 1'b0;
    repeat (40) @(posedge i_clk);
    i_ce <= 1'b1;
    rd(tmr_pkg::OFF_COUNT, d2, r);
    chk(32'(d2 - d < 32'h10), 32'h1);
    wok(tmr_pkg::OFF_CTRL, 32'h0);
    wok(tmr_pkg::OFF_FLAGS, 32'h1);
    rchk(tmr_pkg::OFF_FLAGS, 32'h0, 32'h1);
    $display("normal mode test done");
    wok(tmr_pkg::OFF_CTRL, {28'h0, tmr_pkg::MODE_PWM9});
    wok(tmr_pkg::OFF_CMPA, 32'h0000ABCD);
    rchk(tmr_pkg::OFF_CMPA, 32'h000001CD, 32'hFFFF);
    run_case(tmr_pkg::MODE_CLR_A, tmr_pkg::ACT_TOGGLE, 16'h9, 16'h0);
    wok(tmr_pkg::OFF_CTRL, {21'h0, tmr_pkg::CS_DIV1, 2'h0,
      tmr_pkg::ACT_TOGGLE, tmr_pkg::MODE_CLR_A});
    hi = 0;
    repeat (25) begin
      @(negedge i_clk);
      hi += wave_a | oe_a;
    end
    chk(32'(hi), 32'h0);
    run_case(tmr_pkg::MODE_CLR_A, tmr_pkg::ACT_SET, 16'h9, 16'h0);
    run_case(tmr_pkg::MODE_CLR_A, tmr_pkg::ACT_CLEAR, 16'h9, 16'h0);
    run_case(tmr_pkg::MODE_CLR_CAPT, tmr_pkg::ACT_TOGGLE, 16'h3,
      16'h5);
    // a count above top must pass the wrap before top can match again
    wok(tmr_pkg::OFF_COUNT, 32'h0000FFF0);
    wok(tmr_pkg::OFF_FLAGS, 32'hF);
    wok(tmr_pkg::OFF_CTRL, {21'h0, tmr_pkg::CS_DIV1, 4'h0,
      tmr_pkg::MODE_CLR_CAPT});
    repeat (40) @(posedge i_clk);
    wok(tmr_pkg::OFF_CTRL, 32'h0);
    rchk(tmr_pkg::OFF_FLAGS, 32'h9, 32'h9);
    $display("low top test done");
    for (int m = 5; m < 8; m++) begin
      for (int a = 2; a < 4; a++) begin
        c = 16'($random(seed)) & top_of(4'(m), 16'h0, 16'h0);
        run_case(4'(m), 2'(a), c, 16'h0);
      end
    end
    run_case(tmr_pkg::MODE_PWM8, tmr_pkg::ACT_CLEAR, 16'h0, 16'h0);
    run_case(tmr_pkg::MODE_PWM8, tmr_pkg::ACT_SET, 16'hFF, 16'h0);
    cap = 16'h10 + (16'($random(seed)) & 16'h3F);
    c = 16'($random(seed)) & 16'hF;
    run_case(tmr_pkg::MODE_PWM_CAPT, tmr_pkg::ACT_CLEAR, c, cap);
    run_case(tmr_pkg::MODE_PWM_A, tmr_pkg::ACT_TOGGLE, 16'h7, 16'h0);
    run_case(tmr_pkg::MODE_PWM_A, tmr_pkg::ACT_CLEAR, 16'h14, 16'h0);
    test_done();
  end
endmodule
